/* File: hw/xbr_cfg.svh */
`ifndef XBR_CFG_SVH
`define XBR_CFG_SVH

`define XBR_ADDR_ROUTE_A      8'he1
`define XBR_ADDR_ROUTE_B      8'he2
`define XBR_ROUTE_A_RESET     8'h00
`define XBR_ROUTE_B_RESET     8'h00

`define XBR_A_CMP0_BIT        7
`define XBR_A_ECI_BIT         6
`define XBR_A_CNT_MSB         5
`define XBR_A_CNT_LSB         3
`define XBR_A_ASYNC_A_BIT     2
`define XBR_A_SYNC_BIT        1
`define XBR_A_TWO_WIRE_BIT    0

`define XBR_B_INVERTED_SYSTEM_CLOCK_BIT      7
`define XBR_B_T2_CAPT_BIT     6
`define XBR_B_T2_CNT_BIT      5
`define XBR_B_IRQ1_BIT        4
`define XBR_B_T1_CNT_BIT      3
`define XBR_B_IRQ0_BIT        2
`define XBR_B_T0_CNT_BIT      1
`define XBR_B_CMP1_BIT        0

`define XBR_CNT_MAX           3'h5
`define XBR_NUM_SIG           24
`define XBR_NUM_PIN           32
`define XBR_PORT1_BASE        8

`endif

/* File: hw/xbr_pkg.sv */
package xbr_pkg;

  // Peripheral signals in crossbar priority order; the code is the index.
  typedef enum logic [4:0] {
    XBR_SIG_ASYNC_TX    = 5'b00000,
    XBR_SIG_ASYNC_RX    = 5'b00001,
    XBR_SIG_SYNC_SCK    = 5'b00010,
    XBR_SIG_SYNC_MISO   = 5'b00011,
    XBR_SIG_SYNC_MOSI   = 5'b00100,
    XBR_SIG_SYNC_NSS    = 5'b00101,
    XBR_SIG_TW_DATA     = 5'b00110,
    XBR_SIG_TW_CLOCK    = 5'b00111,
    XBR_SIG_CHAN0       = 5'b01000,
    XBR_SIG_CHAN1       = 5'b01001,
    XBR_SIG_CHAN2       = 5'b01010,
    XBR_SIG_CHAN3       = 5'b01011,
    XBR_SIG_CHAN4       = 5'b01100,
    XBR_SIG_EXT_COUNT   = 5'b01101,
    XBR_SIG_CMP0        = 5'b01110,
    XBR_SIG_CMP1        = 5'b01111,
    XBR_SIG_T0_COUNT    = 5'b10000,
    XBR_SIG_IRQ0_N      = 5'b10001,
    XBR_SIG_T1_COUNT    = 5'b10010,
    XBR_SIG_IRQ1_N      = 5'b10011,
    XBR_SIG_T2_COUNT    = 5'b10100,
    XBR_SIG_T2_CAPTURE  = 5'b10101,
    XBR_SIG_INVERTED_SYSTEM_CLOCK_INV  = 5'b10110,
    XBR_SIG_SPARE       = 5'b10111
  } xbr_sig_t;

  typedef logic [4:0] xbr_pin_idx_t;

endpackage

/* File: hw/xbr_pin_drive.sv */
`timescale 1ns/1ps
`default_nettype none

// One port pin: while the crossbar is on, either the owning peripheral or the port latch drives it.
module xbr_pin_drive
  import xbr_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic gate_en_i,
  input  wire logic claimed_i,
  input  wire logic per_out_i,
  input  wire logic per_oe_i,
  input  wire logic latch_i,
  output var  logic pin_o,
  output var  logic pin_oe_o
);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_o    <= 1'b1;
      pin_oe_o <= 1'b0;
    end else if (!gate_en_i) begin
      // While the crossbar is off the pin is an input only.
      pin_o    <= 1'b1;
      pin_oe_o <= 1'b0;
    end else if (claimed_i) begin
      pin_o    <= per_out_i;
      pin_oe_o <= per_oe_i;
    end else begin
      // Open-drain latch drive: a one releases the pin.
      pin_o    <= latch_i;
      pin_oe_o <= ~latch_i;
    end
  end

endmodule

`default_nettype wire

/* File: hw/xbr_crossbar.sv */
`timescale 1ns/1ps
`default_nettype none
`include "xbr_cfg.svh"

// The pin map is a pure function of the two route registers and the port-one
// mode, rebuilt every cycle, so a register write needs no separate apply step.
module xbr_crossbar
  import xbr_pkg::*;
#(
  parameter int NUM_SIG = `XBR_NUM_SIG,
  parameter int NUM_PIN = `XBR_NUM_PIN
) (
  input  wire logic               MCLK_I,
  input  wire logic               RSTN_I,
  input  wire logic [7:0]         SFR_ADDR_I,
  input  wire logic               SFR_WE_I,
  input  wire logic [7:0]         SFR_WDATA_I,
  output var  logic [7:0]         SFR_RDATA_O,
  input  wire logic               XBAR_GLOBAL_EN_I,
  input  wire logic [7:0]         PORT_ONE_INPUT_MODE_I,
  input  wire logic [NUM_PIN-1:0] PORT_LATCH_I,
  input  wire logic [NUM_SIG-1:0] PER_OUT_I,
  input  wire logic [NUM_SIG-1:0] PER_OE_I,
  output var  logic [NUM_SIG-1:0] PER_IN_O,
  output var  logic [NUM_SIG-1:0] PER_ROUTED_O,
  input  wire logic [NUM_PIN-1:0] PIN_I,
  output var  logic [NUM_PIN-1:0] PIN_O,
  output var  logic [NUM_PIN-1:0] PIN_OE_O
);

  logic [7:0]         route_a;
  logic [7:0]         route_b;
  logic [2:0]         chan_count;
  logic [NUM_SIG-1:0] sig_en;
  logic [NUM_PIN-1:0] pin_skip;
  logic [NUM_PIN-1:0] pin_claimed;
  logic [NUM_PIN-1:0] pin_out;
  logic [NUM_PIN-1:0] pin_oe;
  xbr_pin_idx_t       sig_pin [NUM_SIG];
  logic [NUM_SIG-1:0] sig_placed;
  logic [NUM_SIG-1:0] next_per_in;
  logic [7:0]         next_rdata;

  // Port one is the second byte of pins; its input-mode bits pick the skipped ones.
  localparam int PORT_WIDTH = 8;

  // Software configuration registers. Only the two route registers are decoded here;
  // a write to any other address is dropped. All eight bits are kept, so a reserved
  // channel count still reads back exactly as written.
  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      route_a <= `XBR_ROUTE_A_RESET;
      route_b <= `XBR_ROUTE_B_RESET;
    end else if (SFR_WE_I) begin
      if (SFR_ADDR_I == `XBR_ADDR_ROUTE_A) begin
        route_a <= SFR_WDATA_I;
      end
      if (SFR_ADDR_I == `XBR_ADDR_ROUTE_B) begin
        route_b <= SFR_WDATA_I;
      end
    end
  end

  // Read data follows the address one clock later; unmapped addresses read zero.
  // Reads need no strobe, so polling one register only means holding its address.
  always_comb begin
    case (SFR_ADDR_I)
      `XBR_ADDR_ROUTE_A: next_rdata = route_a;
      `XBR_ADDR_ROUTE_B: next_rdata = route_b;
      default:           next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      SFR_RDATA_O <= 8'h00;
    end else begin
      SFR_RDATA_O <= next_rdata;
    end
  end

  // A reserved count routes no channel rather than guessing a width.
  // Software must not rely on this, since those codes stay reserved.
  assign chan_count = (route_a[`XBR_A_CNT_MSB:`XBR_A_CNT_LSB] > `XBR_CNT_MAX) ? 3'h0
                    : route_a[`XBR_A_CNT_MSB:`XBR_A_CNT_LSB];

  // Per-signal enables, indexed by priority.
  // Index 23 has no peripheral behind it and is never routed.
  always_comb begin
    sig_en                     = '0;
    sig_en[XBR_SIG_ASYNC_TX]   = route_a[`XBR_A_ASYNC_A_BIT];
    sig_en[XBR_SIG_ASYNC_RX]   = route_a[`XBR_A_ASYNC_A_BIT];
    sig_en[XBR_SIG_SYNC_SCK]   = route_a[`XBR_A_SYNC_BIT];
    sig_en[XBR_SIG_SYNC_MISO]  = route_a[`XBR_A_SYNC_BIT];
    sig_en[XBR_SIG_SYNC_MOSI]  = route_a[`XBR_A_SYNC_BIT];
    sig_en[XBR_SIG_SYNC_NSS]   = route_a[`XBR_A_SYNC_BIT];
    sig_en[XBR_SIG_TW_DATA]    = route_a[`XBR_A_TWO_WIRE_BIT];
    sig_en[XBR_SIG_TW_CLOCK]   = route_a[`XBR_A_TWO_WIRE_BIT];
    sig_en[XBR_SIG_CHAN0]      = chan_count > 3'h0;
    sig_en[XBR_SIG_CHAN1]      = chan_count > 3'h1;
    sig_en[XBR_SIG_CHAN2]      = chan_count > 3'h2;
    sig_en[XBR_SIG_CHAN3]      = chan_count > 3'h3;
    sig_en[XBR_SIG_CHAN4]      = chan_count > 3'h4;
    sig_en[XBR_SIG_EXT_COUNT]  = route_a[`XBR_A_ECI_BIT];
    sig_en[XBR_SIG_CMP0]       = route_a[`XBR_A_CMP0_BIT];
    sig_en[XBR_SIG_CMP1]       = route_b[`XBR_B_CMP1_BIT];
    sig_en[XBR_SIG_T0_COUNT]   = route_b[`XBR_B_T0_CNT_BIT];
    sig_en[XBR_SIG_IRQ0_N]     = route_b[`XBR_B_IRQ0_BIT];
    sig_en[XBR_SIG_T1_COUNT]   = route_b[`XBR_B_T1_CNT_BIT];
    sig_en[XBR_SIG_IRQ1_N]     = route_b[`XBR_B_IRQ1_BIT];
    sig_en[XBR_SIG_T2_COUNT]   = route_b[`XBR_B_T2_CNT_BIT];
    sig_en[XBR_SIG_T2_CAPTURE] = route_b[`XBR_B_T2_CAPT_BIT];
    sig_en[XBR_SIG_INVERTED_SYSTEM_CLOCK_INV] = route_b[`XBR_B_INVERTED_SYSTEM_CLOCK_BIT];
  end

  // Port-one pins in analog mode are invisible to the assignment walk.
  // A skipped pin stays unclaimed, so it keeps following its port latch.
  always_comb begin
    pin_skip = '0;
    for (int i = 0; i < PORT_WIDTH; i++) begin
      pin_skip[`XBR_PORT1_BASE + i] = ~PORT_ONE_INPUT_MODE_I[i];
    end
  end

  // Walk signals in priority order, each taking the next pin not skipped.
  // Signals that find no pin left are simply not routed.
  // The pointer only moves forward, so no pin is ever handed out twice, and the
  // inner loop steps over a whole run of skipped pins in one pass.
  always_comb begin
    int ptr;
    ptr        = 0;
    sig_placed = '0;
    for (int s = 0; s < NUM_SIG; s++) begin
      sig_pin[s] = '0;
      if (sig_en[s]) begin
        for (int k = 0; k < NUM_PIN; k++) begin
          if (ptr < NUM_PIN && pin_skip[ptr]) begin
            ptr = ptr + 1;
          end
        end
        if (ptr < NUM_PIN) begin
          sig_pin[s]    = xbr_pin_idx_t'(ptr);
          sig_placed[s] = 1'b1;
          ptr           = ptr + 1;
        end
      end
    end
  end

  // Build the pin-side view: which pin is claimed and what drives it.
  // The peripheral's own enable sets the direction, so routed inputs stay released.
  always_comb begin
    pin_claimed = '0;
    pin_out     = '1;
    pin_oe      = '0;
    for (int s = 0; s < NUM_SIG; s++) begin
      if (sig_placed[s]) begin
        pin_claimed[sig_pin[s]] = 1'b1;
        if (s == int'(XBR_SIG_INVERTED_SYSTEM_CLOCK_INV)) begin
          // The clock arrives as a sampled level, so the pin shows its inverse
          // one clock late; it is a marker, not a clean clock.
          pin_out[sig_pin[s]] = ~PER_OUT_I[s];
        end else begin
          pin_out[sig_pin[s]] = PER_OUT_I[s];
        end
        pin_oe[sig_pin[s]] = PER_OE_I[s];
      end
    end
  end

  // Inputs of unrouted peripherals idle high, so active-low lines stay quiet.
  // Analog port-one pins are never claimed, so their levels reach no peripheral.
  always_comb begin
    for (int s = 0; s < NUM_SIG; s++) begin
      next_per_in[s] = (sig_placed[s] && XBAR_GLOBAL_EN_I) ? PIN_I[sig_pin[s]] : 1'b1;
    end
  end

  // Both peripheral-side views are registered so they line up with the pin flops.
  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      PER_IN_O     <= '1;
      PER_ROUTED_O <= '0;
    end else begin
      PER_IN_O     <= next_per_in;
      PER_ROUTED_O <= sig_placed & {NUM_SIG{XBAR_GLOBAL_EN_I}};
    end
  end

  // One drive flop per pin; the global enable reaches every pin in the same cycle.
  for (genvar p = 0; p < NUM_PIN; p++) begin : g_pin
    xbr_pin_drive u_pin (
      .clk_i     (MCLK_I),
      .rst_n_i   (RSTN_I),
      .gate_en_i (XBAR_GLOBAL_EN_I),
      .claimed_i (pin_claimed[p]),
      .per_out_i (pin_out[p]),
      .per_oe_i  (pin_oe[p]),
      .latch_i   (PORT_LATCH_I[p]),
      .pin_o     (PIN_O[p]),
      .pin_oe_o  (PIN_OE_O[p])
    );
  end

endmodule

`default_nettype wire

/* File: sim/xbr_crossbar_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module xbr_crossbar_monitor
  import xbr_pkg::*;
#(parameter int NUM_SIG = 24, parameter int NUM_PIN = 32) (
  input wire logic               MCLK_I,
  input wire logic               RSTN_I,
  input wire logic [7:0]         SFR_ADDR_I,
  input wire logic               SFR_WE_I,
  input wire logic [7:0]         SFR_WDATA_I,
  input wire logic [7:0]         SFR_RDATA_O,
  input wire logic               XBAR_GLOBAL_EN_I,
  input wire logic [NUM_PIN-1:0] PORT_LATCH_I,
  input wire logic [NUM_SIG-1:0] PER_OUT_I,
  input wire logic [NUM_SIG-1:0] PER_OE_I,
  input wire logic [NUM_SIG-1:0] PER_IN_O,
  input wire logic [NUM_SIG-1:0] PER_ROUTED_O,
  input wire logic [NUM_PIN-1:0] PIN_I,
  input wire logic [NUM_PIN-1:0] PIN_O,
  input wire logic [NUM_PIN-1:0] PIN_OE_O
);
  logic [7:0]         ra;
  logic [7:0]         rb;
  logic [NUM_SIG-1:0] exp_rt;
  logic               en;
  assign en = XBAR_GLOBAL_EN_I;
  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ra <= 8'h00;
      rb <= 8'h00;
    end else if (SFR_WE_I && SFR_ADDR_I == 8'he1) begin
      ra <= SFR_WDATA_I;
    end else if (SFR_WE_I && SFR_ADDR_I == 8'he2) begin
      rb <= SFR_WDATA_I;
    end
  end
  // Every signal fits in the 24 pins left after the worst skip, so all enabled ones hold a pin.
  always_comb begin
    exp_rt = '0;
    exp_rt[1:0] = {2{ra[2]}};
    exp_rt[5:2] = {4{ra[1]}};
    exp_rt[7:6] = {2{ra[0]}};
    for (int i = 0; i < 5; i++) begin
      exp_rt[8+i] = (ra[5:3] < 3'h6) && (i < ra[5:3]);
    end
    exp_rt[14:13] = {ra[7], ra[6]};
    exp_rt[22:15] = rb;
  end
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (!RSTN_I);
  a_global_off: assert property (!en |=> PIN_OE_O == '0 && &PIN_O && PER_ROUTED_O == '0
    && &PER_IN_O) else $error("pins active while crossbar is off");
  a_routed_set: assert property (en |=> PER_ROUTED_O == $past(exp_rt))
    else $error("routed set differs from register fields");
  a_unrouted_high: assert property (en |=> &(PER_IN_O | PER_ROUTED_O))
    else $error("unrouted input not high");
  a_tx_pin: assert property (en && ra[2] |=> PIN_O[0] == $past(PER_OUT_I[0])
    && PIN_OE_O[0] == $past(PER_OE_I[0])) else $error("transmit line not on pin 0");
  a_rx_in: assert property (en && ra[2] |=> PER_IN_O[1] == $past(PIN_I[1]))
    else $error("receive line not fed from pin 1");
  a_tw_clock: assert property (en && ra[2:0] == 3'h5 |=> PIN_O[3] == $past(PER_OUT_I[7]))
    else $error("two-wire clock not on pin 3");
  a_latch_follow: assert property (en && ra == 8'h00 && rb == 8'h00
    |=> PIN_O == $past(PORT_LATCH_I) && PIN_OE_O == ~$past(PORT_LATCH_I))
    else $error("idle pins do not follow latch");
  a_reg_readback: assert property ((SFR_ADDR_I == 8'he2 && !SFR_WE_I) ##1
    ($stable(SFR_ADDR_I) && !SFR_WE_I) |-> SFR_RDATA_O == rb) else $error("bad readback");
  cover property (en && ra[5:3] == 3'h5);
  cover property (en && rb[7]);
  cover property (!en ##1 en);
  cover property (en && ra[2:0] == 3'h5 && rb == 8'h14);
endmodule
bind xbr_crossbar xbr_crossbar_monitor #(.NUM_SIG(NUM_SIG), .NUM_PIN(NUM_PIN)) u_mon (
  .MCLK_I(MCLK_I), .RSTN_I(RSTN_I), .SFR_ADDR_I(SFR_ADDR_I), .SFR_WE_I(SFR_WE_I),
  .SFR_WDATA_I(SFR_WDATA_I), .SFR_RDATA_O(SFR_RDATA_O), .XBAR_GLOBAL_EN_I(XBAR_GLOBAL_EN_I),
  .PORT_LATCH_I(PORT_LATCH_I), .PER_OUT_I(PER_OUT_I), .PER_OE_I(PER_OE_I),
  .PER_IN_O(PER_IN_O), .PER_ROUTED_O(PER_ROUTED_O), .PIN_I(PIN_I), .PIN_O(PIN_O),
  .PIN_OE_O(PIN_OE_O));
`default_nettype wire

/* File: sim/xbr_board.sv */
`timescale 1ns/1ps
`default_nettype none
module xbr_board #(parameter int NUM_PIN = 32) (
  input  wire logic [NUM_PIN-1:0] pin_o_i,
  input  wire logic [NUM_PIN-1:0] pin_oe_i,
  input  wire logic [NUM_PIN-1:0] ext_en_i,
  input  wire logic [NUM_PIN-1:0] ext_val_i,
  output var  logic [NUM_PIN-1:0] pin_i_o
);
  // A pin nobody drives floats up through its pull-up, never keeping the last value.
  assign pin_i_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & ((ext_en_i & ext_val_i) | ~ext_en_i));
endmodule
`default_nettype wire

/* File: sim/port_crossbar_routing_enables_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module port_crossbar_routing_enables_tb_top;
  import xbr_pkg::*;
  logic        mclk = 1'b0, rstn = 1'b0, we = 1'b0, gen = 1'b0;
  logic [7:0]  addr = 8'h00, wdata = 8'h00, mode = 8'hff, rdata;
  logic [31:0] latch = 32'h0f0f_5a5a, ext_en = '0, ext_val = '0, pin_i, pin_o, pin_oe;
  logic [23:0] pout = 24'h5a_c3a5, poe = 24'h7e_d3b5, pin_in, routed;
  logic [7:0]  av [5] = '{8'h01, 8'h02, 8'h04, 8'h40, 8'h80};
  logic [23:0] ev [5] = '{24'hc0, 24'h3c, 24'h03, 24'h2000, 24'h4000};
  int          mismatches = 0, cmp_count = 0;
  always #12.5 mclk = ~mclk;
  xbr_crossbar DUT (.MCLK_I(mclk), .RSTN_I(rstn), .SFR_ADDR_I(addr), .SFR_WE_I(we),
    .SFR_WDATA_I(wdata), .SFR_RDATA_O(rdata), .XBAR_GLOBAL_EN_I(gen),
    .PORT_ONE_INPUT_MODE_I(mode), .PORT_LATCH_I(latch), .PER_OUT_I(pout), .PER_OE_I(poe),
    .PER_IN_O(pin_in), .PER_ROUTED_O(routed), .PIN_I(pin_i), .PIN_O(pin_o), .PIN_OE_O(pin_oe));
  xbr_board u_board (.pin_o_i(pin_o), .pin_oe_i(pin_oe), .ext_en_i(ext_en),
    .ext_val_i(ext_val), .pin_i_o(pin_i));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    addr = a;
    wdata = d;
    we = 1'b1;
    @(negedge mclk);
    we = 1'b0;
    @(negedge mclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge mclk);
    addr = a;
    @(negedge mclk);
    chk(32'(rdata), 32'(exp));
  endtask
  task automatic settle();
    repeat (2) @(negedge mclk);
  endtask
  task automatic print_verdict();
    if (mismatches == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    #100000;
    mismatches++;
    print_verdict();
  end
  initial begin
    repeat (16) @(negedge mclk);
    rstn = 1'b1;
    gen = 1'b1;
    rd(8'he1, 8'h00);
    wr(8'he3, 8'hff);
    rd(8'he3, 8'h00);
    chk(pin_o, latch);
    chk(pin_oe, ~latch);
    for (int b = 0; b < 8; b++) begin
      wr(8'he2, 8'(1 << b));
      rd(8'he2, 8'(1 << b));
      chk(32'(routed), 32'(1) << (15 + b));
    end
    wr(8'he2, 8'h00);
    // Counts 110 and 111 are never written: software may not use them.
    for (int c = 0; c < 6; c++) begin
      wr(8'he1, 8'(c << 3));
      chk(32'(routed), ((32'(1) << c) - 1) << 8);
    end
    for (int i = 0; i < 5; i++) begin
      wr(8'he1, av[i]);
      chk(32'(routed), 32'(ev[i]));
    end
    wr(8'he1, 8'h00);
    wr(8'he2, 8'h80);
    chk(32'({pin_o[0], pin_oe[0]}), 32'({~pout[22], poe[22]}));
    wr(8'he2, 8'h00);
    mode = 8'he3;
    wr(8'he1, 8'h2e);
    chk(32'(pin_o[13:0]), 32'({pout[12], latch[12:10], pout[11:8], pout[5:0]}));
    chk(32'(pin_oe[13:0]), 32'({poe[12], ~latch[12:10], poe[11:8], poe[5:0]}));
    ext_en[1] = 1'b1;
    for (int v = 0; v < 2; v++) begin
      ext_val[1] = v[0];
      settle();
      chk(32'(pin_in[1]), 32'(v[0]));
    end
    // Two-wire behind async serial, then both interrupts on the next free pins.
    wr(8'he2, 8'h14);
    wr(8'he1, 8'h05);
    chk(32'(routed), 32'h000a_00c3);
    chk(32'(pin_o[5:0]), 32'({pout[19], pout[17], pout[7:6], pout[1:0]}));
    chk(32'(pin_oe[5:0]), 32'({poe[19], poe[17], poe[7:6], poe[1:0]}));
    gen = 1'b0;
    settle();
    chk(pin_oe, 32'h0);
    chk(32'(routed), 32'h0);
    gen = 1'b1;
    settle();
    print_verdict();
  end
endmodule
`default_nettype wire
